// ==== logic/boot_load_sequencer.v ====
`timescale 1ns/1ns
`default_nettype none

module boot_load_sequencer (
   input wire clk,            // system clock
   input wire rst_n,          // async reset, active low
   input wire startWrite,     // host wrote 1 to the start bit
   input wire loadOk,         // loader finished successfully, pulse
   input wire loadFail,       // loader aborted, pulse
   output reg bootLoadStart,  // start bit, also the loader run level
   output reg bootLoadDone    // success flag, read only to the host
);

   wire loadEnd;

   assign loadEnd = loadOk | loadFail;

   // start bit self clears at the end; a new start in that cycle wins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootLoadStart <= 1'b0;
      end else if (startWrite) begin
         bootLoadStart <= 1'b1;
      end else if (loadEnd && bootLoadStart) begin
         bootLoadStart <= 1'b0;
      end
   end

   // done flag only on success; a fresh start wipes the old result, but a success in that cycle wins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootLoadDone <= 1'b0;
      end else if (loadOk && bootLoadStart) begin
         bootLoadDone <= 1'b1;
      end else if (startWrite || (loadFail && bootLoadStart)) begin
         bootLoadDone <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== logic/txen_ctrl_defines.vh ====
`ifndef TXEN_CTRL_DEFINES_VH
`define TXEN_CTRL_DEFINES_VH

// register offsets on the serial control port
`define ADDR_TX_GATE_SM        12'h58D
`define ADDR_BLANKING_CONTROL  12'h596
`define ADDR_IRQ_ENABLE_LOW    12'h597
`define ADDR_IRQ_ENABLE_HIGH   12'h598
`define ADDR_FLUSH_CONTROL     12'h599
`define ADDR_BOOT_LOADER       12'h705
`define ADDR_SYNTH_PD0         12'h790

// field positions
`define BIT_FSM_ENABLE         0
`define BIT_SOFT_OVERRIDE      2
`define BIT_SOFT_VALUE         3
`define BIT_FLUSH_ENABLE       0
`define BIT_IRQ_ENABLE_HIGH    0
`define BIT_BOOT_START         0
`define BIT_BOOT_DONE          1
`define BIT_SYNTH_PD_BYPASS    7

// reset values
`define RST_FSM_ENABLE         1'h0
`define RST_SOFT_OVERRIDE      1'h0
`define RST_SOFT_VALUE         1'h0
`define RST_FLUSH_ENABLE       1'h1
`define RST_IRQ_ENABLES        9'h000
`define RST_SYNTH_PD0          8'h02

// interrupt enable bit assignment
`define IRQ_LANE_FIFO          0
`define IRQ_UNEXPECTED_CTRL    1
`define IRQ_NOT_IN_TABLE       2
`define IRQ_BAD_DISPARITY      3
`define IRQ_DESKEW             4
`define IRQ_INIT_LANE_SYNC     5
`define IRQ_GOOD_CHECKSUM      6
`define IRQ_FRAME_SYNC         7
`define IRQ_CODE_GROUP_SYNC    8
`define IRQ_COUNT              9

`endif

// ==== logic/txen_irq_boot_control_regs.v ====
// Behaviour
// - transmit-gate state machine runs only while its paged enable bit is 1.
// - paged controls are written to, and read from, the selected converter.
// - override bit set takes transmit-gate control from serial port, not pin.
// - under override, the soft value bit is the converter's gate status.
// - nine link interrupt enables, 7:0 low register, 8 high; gate sources.
// - enable bits 0..3: FIFO, unexpected control, not-in-table, disparity.
// - enable bits 4..8: deskew, lane sync, checksum, frame sync, code group.
// - flush enable is paged, resets to 1, drives datapath flush.
// - host writes 1 to start loader; bit self clears on success or fail.
// - read-only done flag set only on successful load.
`timescale 1ns/1ns
`default_nettype none
`include "txen_ctrl_defines.vh"

module txen_irq_boot_control_regs #(
   parameter NUM_CONV = 2 // number of main converters
) (
   input wire clk,                          // 20 MHz register clock
   input wire rst_n,                        // async reset, active low
   input wire [11:0] regAddr,               // register address
   input wire [7:0] regWrData,              // write data
   input wire regWrite,                     // write strobe, one cycle
   input wire regRead,                      // read strobe, one cycle
   output reg [7:0] regRdData,              // read data, held until next read
   input wire [NUM_CONV-1:0] main_converter_page_select, // page mask
   input wire [NUM_CONV-1:0] tx_gate_pin,   // transmit-gate pins, async
   output wire [NUM_CONV-1:0] tx_gate_fsm_enable, // state machine run
   output wire [NUM_CONV-1:0] txGateStatus, // effective gate status
   output wire [NUM_CONV-1:0] flushEnable,  // datapath flush enable
   input wire [`IRQ_COUNT-1:0] linkIrqSource, // link protection events
   output wire [`IRQ_COUNT-1:0] linkIrqGated, // enabled events only
   output reg [`IRQ_COUNT-1:0] link_protect_irq_enables, // enable bits
   input wire loadOk,                       // boot loader success pulse
   input wire loadFail,                     // boot loader failure pulse
   output wire boot_load_start,             // loader run level
   output wire boot_load_done,              // loader success flag
   output reg [7:0] synthPowerdown          // synth power-down bits
);

   // paged storage, one bit per converter
   reg [NUM_CONV-1:0] fsmEnable;
   reg [NUM_CONV-1:0] soft_tx_gate_override;
   reg [NUM_CONV-1:0] soft_tx_gate_value;
   reg [NUM_CONV-1:0] flushBit;
   reg [NUM_CONV-1:0] pinMeta;
   reg [NUM_CONV-1:0] pinSync;
   reg [7:0] next_rdData;
   wire wrGateSm;
   wire wrBlanking;
   wire wrFlush;
   wire wrIrqLow;
   wire wrIrqHigh;
   wire wrSynth;
   wire bootStartWrite;
   integer readIdx;
   integer k;

   // address decode for writes
   assign wrGateSm = regWrite && (regAddr == `ADDR_TX_GATE_SM);
   assign wrBlanking = regWrite && (regAddr == `ADDR_BLANKING_CONTROL);
   assign wrFlush = regWrite && (regAddr == `ADDR_FLUSH_CONTROL);
   assign wrIrqLow = regWrite && (regAddr == `ADDR_IRQ_ENABLE_LOW);
   assign wrIrqHigh = regWrite && (regAddr == `ADDR_IRQ_ENABLE_HIGH);
   assign wrSynth = regWrite && (regAddr == `ADDR_SYNTH_PD0);
   assign bootStartWrite = regWrite && (regAddr == `ADDR_BOOT_LOADER) &&
                           regWrData[`BIT_BOOT_START];

   // pins are asynchronous, so two flops before any use
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= {NUM_CONV{1'b0}};
         pinSync <= {NUM_CONV{1'b0}};
      end else begin
         pinMeta <= tx_gate_pin;
         pinSync <= pinMeta;
      end
   end

   // one copy of every paged control per converter
   genvar g;
   generate
      for (g = 0; g < NUM_CONV; g = g + 1) begin : conv
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               fsmEnable[g] <= `RST_FSM_ENABLE;
               soft_tx_gate_override[g] <= `RST_SOFT_OVERRIDE;
               soft_tx_gate_value[g] <= `RST_SOFT_VALUE;
               flushBit[g] <= `RST_FLUSH_ENABLE;
            end else if (main_converter_page_select[g]) begin
               if (wrGateSm) begin
                  fsmEnable[g] <= regWrData[`BIT_FSM_ENABLE];
               end
               if (wrBlanking) begin
                  soft_tx_gate_override[g] <=
                     regWrData[`BIT_SOFT_OVERRIDE];
                  soft_tx_gate_value[g] <= regWrData[`BIT_SOFT_VALUE];
               end
               if (wrFlush) begin
                  flushBit[g] <= regWrData[`BIT_FLUSH_ENABLE];
               end
            end
         end

         // override picks the soft value, else the pin decides
         assign txGateStatus[g] = soft_tx_gate_override[g] ?
            soft_tx_gate_value[g] : pinSync[g];
      end
   endgenerate

   assign tx_gate_fsm_enable = fsmEnable;
   assign flushEnable = flushBit;

   // unpaged interrupt enables, one set shared by all converters;
   // the high register holds a single live bit
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_protect_irq_enables <= `RST_IRQ_ENABLES;
      end else begin
         if (wrIrqLow) begin
            link_protect_irq_enables[7:0] <= regWrData;
         end
         if (wrIrqHigh) begin
            // upper reserved bits are dropped on purpose
            link_protect_irq_enables[8] <=
               regWrData[`BIT_IRQ_ENABLE_HIGH];
         end
      end
   end

   // synth power-down is plain storage; the host alone decides
   // when the bypass bit is set
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         synthPowerdown <= `RST_SYNTH_PD0;
      end else if (wrSynth) begin
         synthPowerdown <= regWrData;
      end
   end

   // one gate per source; a cleared enable blocks only its own
   // source and leaves the other eight untouched
   genvar s;
   generate
      for (s = 0; s < `IRQ_COUNT; s = s + 1) begin : irqGate
         assign linkIrqGated[s] = linkIrqSource[s] &
            link_protect_irq_enables[s];
      end
   endgenerate

   boot_load_sequencer u_boot (
      .clk(clk),
      .rst_n(rst_n),
      .startWrite(bootStartWrite),
      .loadOk(loadOk),
      .loadFail(loadFail),
      .bootLoadStart(boot_load_start),
      .bootLoadDone(boot_load_done)
   );

   // reads show the lowest-numbered selected converter, so a
   // multi-page mask still gives one defined answer; with no page
   // selected the first converter answers
   always @* begin
      readIdx = 0;
      for (k = NUM_CONV - 1; k >= 0; k = k - 1) begin
         if (main_converter_page_select[k]) begin
            readIdx = k;
         end
      end
   end

   // read mux; reserved and unmapped bits stay zero
   always @* begin
      next_rdData = 8'h00;
      case (regAddr)
         `ADDR_TX_GATE_SM: begin
            next_rdData[`BIT_FSM_ENABLE] = fsmEnable[readIdx];
         end
         `ADDR_BLANKING_CONTROL: begin
            next_rdData[`BIT_SOFT_OVERRIDE] =
               soft_tx_gate_override[readIdx];
            next_rdData[`BIT_SOFT_VALUE] = soft_tx_gate_value[readIdx];
         end
         `ADDR_IRQ_ENABLE_LOW: begin
            next_rdData = link_protect_irq_enables[7:0];
         end
         `ADDR_IRQ_ENABLE_HIGH: begin
            next_rdData[`BIT_IRQ_ENABLE_HIGH] = link_protect_irq_enables[8];
         end
         `ADDR_FLUSH_CONTROL: begin
            next_rdData[`BIT_FLUSH_ENABLE] = flushBit[readIdx];
         end
         `ADDR_BOOT_LOADER: begin
            next_rdData[`BIT_BOOT_START] = boot_load_start;
            next_rdData[`BIT_BOOT_DONE] = boot_load_done;
         end
         `ADDR_SYNTH_PD0: begin
            next_rdData = synthPowerdown;
         end
         default: begin
            next_rdData = 8'h00;
         end
      endcase
   end

   // read data is captured on the strobe and held, so status that
   // moves later cannot tear a read already taken
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end
   end

endmodule

`default_nettype wire

// ==== verif/host_port_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
   input wire logic clk, // register clock
   input wire logic [7:0] regRdData, // read data
   output logic [11:0] regAddr, // address
   output logic [7:0] regWrData, // write data
   output logic regWrite, // write strobe
   output logic regRead // read strobe
);
   // idle bus; address and data are scrambled once released
   initial begin
      regAddr = 12'h000;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   // one-cycle write; boot start and power-down bits go this way
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk) #5;
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk) #5;
      regWrite = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask
   // read data is settled at the taking edge; the task returns one edge later
   task automatic rd(input logic [11:0] a);
      @(posedge clk) #5;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clk) #5;
      regRead = 1'b0;
      regAddr = ~a;
      @(posedge clk) #5;
   endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst_n, regWrite, regRead, loadOk, loadFail;
   logic boot_load_start, boot_load_done;
   logic [11:0] regAddr;
   logic [7:0] regWrData, regRdData, synthPowerdown, r;
   logic [1:0] main_converter_page_select, tx_gate_pin;
   logic [1:0] tx_gate_fsm_enable, txGateStatus, flushEnable;
   logic [8:0] linkIrqSource, linkIrqGated, link_protect_irq_enables, en;
   int errorCnt, comparisons, i;
   logic [11:0] addrTab [0:7] = '{12'h58D, 12'h596, 12'h597, 12'h598,
      12'h599, 12'h705, 12'h790, 12'h123};
   logic [7:0] rstTab [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
      8'h02, 8'h00};
   txen_irq_boot_control_regs u_txen_irq_boot_control_regs(.*);
   host_port_model u_host_port_model(.*);
   // 50 ns period
   always #25 clk = ~clk;
   // only override and soft value survive a read of the blanking byte
   function automatic logic [7:0] blank(input logic [7:0] d);
      return d & 8'h0C;
   endfunction
   task check(input logic [8:0] s, input logic [8:0] e);
      comparisons++;
      if (s !== e) begin
         errorCnt++;
         $display("Error %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task rdChk(input logic [11:0] a, input logic [7:0] e);
      u_host_port_model.rd(a);
      check({1'b0, regRdData}, {1'b0, e});
   endtask
   task pulse(input logic ok);
      @(posedge clk) #5;
      loadOk = ok;
      loadFail = !ok;
      @(posedge clk) #5;
      loadOk = 1'b0;
      loadFail = 1'b0;
   endtask
   task summarize;
      $display("errors %0d comparisons %0d", errorCnt, comparisons);
      if (errorCnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog: the sequence is fixed length, a hang is a mismatch
   initial begin
      #400000;
      errorCnt++;
      summarize;
   end
   initial begin
      {clk, rst_n, loadOk, loadFail} = 4'h0;
      {main_converter_page_select, tx_gate_pin} = 4'h4;
      linkIrqSource = 9'h000;
      r = 8'($urandom(32'hFB4C));
      repeat (6) @(posedge clk);
      #5 rst_n = 1'b1;
      check(flushEnable, 2'b11);
      for (i = 0; i < 8; i++) rdChk(addrTab[i], rstTab[i]);
      u_host_port_model.wr(12'h596, 8'hFF);
      rdChk(12'h596, blank(8'hFF));
      check(txGateStatus[0], 1'b1);
      main_converter_page_select = 2'b10;
      tx_gate_pin = 2'b11;
      u_host_port_model.wr(12'h596, 8'h04);
      u_host_port_model.wr(12'h58D, 8'h01);
      u_host_port_model.wr(12'h599, 8'h00);
      main_converter_page_select = 2'b01;
      u_host_port_model.wr(12'h596, 8'h00);
      repeat (3) @(posedge clk);
      check(txGateStatus, 2'b01);
      check(tx_gate_fsm_enable, 2'b10);
      check(flushEnable, 2'b01);
      rdChk(12'h596, 8'h00);
      main_converter_page_select = 2'b10;
      rdChk(12'h596, 8'h04);
      // all-ones first, then all-zeros, then random enables against random events
      for (i = 0; i < 8; i++) begin
         en = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : 9'($urandom);
         u_host_port_model.wr(12'h597, en[7:0]);
         u_host_port_model.wr(12'h598, {7'h7F, en[8]});
         linkIrqSource = 9'($urandom);
         #1 check(linkIrqGated, en & linkIrqSource);
         check(link_protect_irq_enables, en);
         rdChk(12'h598, {7'h00, en[8]});
         rdChk(12'h597, en[7:0]);
      end
      u_host_port_model.wr(12'h705, 8'h01);
      check({boot_load_start, boot_load_done}, 2'b10);
      pulse(1'b0);
      check({boot_load_start, boot_load_done}, 2'b00);
      u_host_port_model.wr(12'h705, 8'h01);
      pulse(1'b1);
      check({boot_load_start, boot_load_done}, 2'b01);
      pulse(1'b0);
      rdChk(12'h705, 8'h02);
      // a restart racing a success pulse: start and success both stick
      u_host_port_model.wr(12'h705, 8'h01);
      fork
         u_host_port_model.wr(12'h705, 8'h01);
         pulse(1'b1);
      join
      check({boot_load_start, boot_load_done}, 2'b11);
      pulse(1'b0);
      check({boot_load_start, boot_load_done}, 2'b00);
      u_host_port_model.wr(12'h790, r);
      rdChk(12'h790, r);
      check(synthPowerdown, r);
      // a mid-run reset must bring the done, flush and power-down defaults back
      @(posedge clk) #5 rst_n = 1'b0;
      @(posedge clk) #5 rst_n = 1'b1;
      check({boot_load_done, flushEnable}, 3'b011);
      rdChk(12'h790, 8'h02);
      summarize;
   end
endmodule
`default_nettype wire

// ==== verif/txen_regs_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module txen_regs_chk #(parameter NUM_CONV = 2) (
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic [11:0] regAddr, // address
   input wire logic [7:0] regWrData, // wdata
   input wire logic regWrite, // write
   input wire logic regRead, // read
   input wire logic [7:0] regRdData, // rdata
   input wire logic [NUM_CONV-1:0] main_converter_page_select, // page
   input wire logic [NUM_CONV-1:0] tx_gate_pin, // pins
   input wire logic [NUM_CONV-1:0] tx_gate_fsm_enable, // fsm run
   input wire logic [NUM_CONV-1:0] txGateStatus, // gate
   input wire logic [NUM_CONV-1:0] flushEnable, // flush
   input wire logic [8:0] linkIrqSource, // events
   input wire logic [8:0] linkIrqGated, // gated
   input wire logic [8:0] link_protect_irq_enables, // enables
   input wire logic loadOk, // ok
   input wire logic loadFail, // fail
   input wire logic boot_load_start, // start
   input wire logic boot_load_done, // done
   input wire logic [7:0] synthPowerdown // power-down
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic bootWr;
   logic wrA;
   // a start write in the same cycle as an end pulse wins
   assign bootWr = regWrite && regAddr == 12'h705 && regWrData[0];
   assign wrA = regWrite && main_converter_page_select[0];
   property p_irqGate;
      linkIrqGated == (linkIrqSource & link_protect_irq_enables);
   endproperty
   a_irqGate: assert property (p_irqGate) else $error("gating bad");
   property p_enLow;
      regWrite && regAddr == 12'h597 |=>
         link_protect_irq_enables[7:0] == $past(regWrData);
   endproperty
   a_enLow: assert property (p_enLow) else $error("low enables");
   property p_enHigh;
      regWrite && regAddr == 12'h598 |=>
         link_protect_irq_enables[8] == $past(regWrData[0]);
   endproperty
   a_enHigh: assert property (p_enHigh) else $error("enable 8");
   property p_soft;
      wrA && regAddr == 12'h596 && regWrData[2] |=>
         txGateStatus[0] == $past(regWrData[3]);
   endproperty
   a_soft: assert property (p_soft) else $error("soft gate");
   property p_fsm;
      wrA && regAddr == 12'h58D |=>
         tx_gate_fsm_enable[0] == $past(regWrData[0]);
   endproperty
   a_fsm: assert property (p_fsm) else $error("fsm enable");
   property p_flush;
      regWrite && main_converter_page_select[1] && regAddr == 12'h599 |=>
         flushEnable[1] == $past(regWrData[0]);
   endproperty
   a_flush: assert property (p_flush) else $error("flush");
   property p_start;
      bootWr |=> boot_load_start &&
         boot_load_done == $past(loadOk && boot_load_start);
   endproperty
   a_start: assert property (p_start) else $error("boot start");
   property p_ok;
      boot_load_start && loadOk && !bootWr |=>
         !boot_load_start && boot_load_done;
   endproperty
   a_ok: assert property (p_ok) else $error("boot ok");
   property p_fail;
      boot_load_start && loadFail && !loadOk && !bootWr |=>
         !boot_load_start && !boot_load_done;
   endproperty
   a_fail: assert property (p_fail) else $error("boot fail");
   property p_resv;
      regRead && regAddr == 12'h596 |=>
         regRdData[7:4] == 4'h0 && regRdData[1:0] == 2'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits");
   c_ok: cover property (boot_load_start && loadOk);
   c_fail: cover property (boot_load_start && loadFail);
   c_irq: cover property (linkIrqGated != 9'h000);
endmodule
bind txen_irq_boot_control_regs txen_regs_chk #(.NUM_CONV(NUM_CONV)) u_chk(.*);
`default_nettype wire
